// ==== baud_gen_pkg.sv ====
/*
 Constants for the serial bit-rate generator: mode encodings,
 prescale and divide counts. Assumes a single core clock domain.
*/
package baud_gen_pkg;
  localparam logic [1:0] SER_MODE_VAR8 = 2'h1;
  localparam logic [1:0] SER_MODE_VAR9 = 2'h3;
  localparam logic [3:0] T1_MODE_AUTO8 = 4'h2;
  localparam int         T1_PRESCALE   = 12;
  localparam int         T2_PRESCALE   = 2;
  localparam logic [4:0] DIV_T1_NORM   = 5'h1F;
  localparam logic [4:0] DIV_T1_DBL    = 5'h0F;
  localparam logic [4:0] DIV_T2        = 5'h0F;
  localparam logic [3:0] PRE12_LAST    = 4'(T1_PRESCALE - 1);
  localparam logic       PRE2_LAST     = 1'(T2_PRESCALE - 1);
  // Counters wake at their top so the first overflow loads the reload
  localparam logic [7:0]  T1_CNT_INIT  = 8'hFF;
  localparam logic [15:0] T2_CNT_INIT  = 16'hFFFF;
endpackage : baud_gen_pkg

// ==== uart_baud_rate_generator.sv ====
/*
 Bit-rate tick generator for the variable-rate serial modes.
 Holds a timer 1 model for its 8-bit auto-reload mode, timer 2 in
 its 16-bit baud mode, and per-direction dividers. Assumes control
 bits arrive synchronous to core_clk; timer 1 overflows from other
 modes may be fed in on t1_ovf_ext.
*/
// Behaviour
// - Rate from timer 1, timer 2, or split
// - Timer 1 rate times two-power doubling over 32
// - Any timer 1 mode overflow accepted
// - Auto-reload: clock over 12 times reload span
// - Sixteen timer 2 overflows per bit
// - Timer 2 counts every two clocks
// - Timer 2 reloads 16 bits on overflow
// - Select bits route timer 2 per direction
// - Transmit and receive rates independent
// - Doubling bit in power control register
// - Mode 01 is 8-bit variable
// - Mode 11 is 9-bit variable
`timescale 1ns/1ns
module uart_baud_rate_generator
  import baud_gen_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Configuration and external timer 1 overflow
  input  wire logic       serial_mode_upper_bit,
  input  wire logic       serial_mode_lower_bit,
  input  wire logic       rate_double_bit,
  input  wire logic [3:0] timer_mode_reg,
  input  wire logic [7:0] timer1_reload_byte,
  input  wire logic       timer1_run,
  input  wire logic       t1_ovf_ext,
  input  wire logic       timer2_tx_source_select,
  input  wire logic       timer2_rx_source_select,
  input  wire logic [7:0] timer2_reload_high,
  input  wire logic [7:0] timer2_reload_low,
  // Ticks and status
  output logic            tx_bit_tick,
  output logic            rx_bit_tick,
  output logic            t1_overflow,
  output logic            t2_overflow
);
  logic [3:0]  pre12_q, pre12_d;
  logic [7:0]  t1_cnt_q, t1_cnt_d;
  logic        pre2_q, pre2_d;
  logic [15:0] t2_cnt_q, t2_cnt_d;
  logic [4:0]  tx_div_q, tx_div_d, rx_div_q, rx_div_d;
  logic        tx_tick_q, tx_tick_d, rx_tick_q, rx_tick_d;
  logic        t1_ovf, t2_ovf, var_mode, t2_baud, t1_auto;

  function automatic logic [4:0] div_last(input logic use_t2, input logic dbl);
    if (use_t2) div_last = DIV_T2;
    else if (dbl) div_last = DIV_T1_DBL;
    else div_last = DIV_T1_NORM;
  endfunction : div_last

  assign var_mode = ({serial_mode_upper_bit, serial_mode_lower_bit} == SER_MODE_VAR8) ||
                    ({serial_mode_upper_bit, serial_mode_lower_bit} == SER_MODE_VAR9);
  assign t2_baud  = timer2_tx_source_select | timer2_rx_source_select;
  assign t1_auto  = (timer_mode_reg == T1_MODE_AUTO8) && timer1_run;

  // Timer 1: prescale by twelve, then 8-bit auto-reload count
  always_comb begin
    pre12_d  = pre12_q;
    t1_cnt_d = t1_cnt_q;
    t1_ovf   = 1'b0;
    if (t1_auto) begin
      pre12_d = (pre12_q == PRE12_LAST) ? 4'h0 : pre12_q + 4'h1;
      if (pre12_q == PRE12_LAST) begin
        if (t1_cnt_q == 8'hFF) begin
          t1_cnt_d = timer1_reload_byte;
          t1_ovf   = 1'b1;
        end else begin
          t1_cnt_d = t1_cnt_q + 8'h01;
        end
      end
    end
    t1_ovf = t1_ovf | t1_ovf_ext;
  end

  // Timer 2: halved clock, 16-bit reload while either select is set
  always_comb begin
    pre2_d   = pre2_q;
    t2_cnt_d = t2_cnt_q;
    t2_ovf   = 1'b0;
    if (t2_baud) begin
      pre2_d = ~pre2_q;
      if (pre2_q == PRE2_LAST) begin
        if (t2_cnt_q == 16'hFFFF) begin
          t2_cnt_d = {timer2_reload_high, timer2_reload_low};
          t2_ovf   = 1'b1;
        end else begin
          t2_cnt_d = t2_cnt_q + 16'h0001;
        end
      end
    end
  end

  // Per-direction source pick and overflow divider
  always_comb begin
    logic tx_src;
    logic rx_src;
    tx_src    = timer2_tx_source_select ? t2_ovf : t1_ovf;
    rx_src    = timer2_rx_source_select ? t2_ovf : t1_ovf;
    tx_div_d  = tx_div_q;
    rx_div_d  = rx_div_q;
    tx_tick_d = 1'b0;
    rx_tick_d = 1'b0;
    if (!var_mode) begin
      tx_div_d = 5'h00;
      rx_div_d = 5'h00;
    end else begin
      if (tx_src) begin
        if (tx_div_q >= div_last(timer2_tx_source_select, rate_double_bit)) begin
          tx_div_d  = 5'h00;
          tx_tick_d = 1'b1;
        end else begin
          tx_div_d = tx_div_q + 5'h01;
        end
      end
      if (rx_src) begin
        if (rx_div_q >= div_last(timer2_rx_source_select, rate_double_bit)) begin
          rx_div_d  = 5'h00;
          rx_tick_d = 1'b1;
        end else begin
          rx_div_d = rx_div_q + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre12_q   <= 4'h0;
      t1_cnt_q  <= T1_CNT_INIT;
      pre2_q    <= 1'b0;
      t2_cnt_q  <= T2_CNT_INIT;
      tx_div_q  <= 5'h00;
      rx_div_q  <= 5'h00;
      tx_tick_q <= 1'b0;
      rx_tick_q <= 1'b0;
      t1_overflow <= 1'b0;
      t2_overflow <= 1'b0;
    end else begin
      pre12_q   <= pre12_d;
      t1_cnt_q  <= t1_cnt_d;
      pre2_q    <= pre2_d;
      t2_cnt_q  <= t2_cnt_d;
      tx_div_q  <= tx_div_d;
      rx_div_q  <= rx_div_d;
      tx_tick_q <= tx_tick_d;
      rx_tick_q <= rx_tick_d;
      t1_overflow <= t1_ovf;
      t2_overflow <= t2_ovf;
    end
  end

  assign tx_bit_tick = tx_tick_q;
  assign rx_bit_tick = rx_tick_q;

  tick_single_a: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_bit_tick |=> !tx_bit_tick) else $error("tx tick longer than one cycle");
  tick_mode_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !var_mode |=> !tx_bit_tick && !rx_bit_tick) else $error("tick outside variable mode");
  t2_pace_a: assert property (@(posedge core_clk) disable iff (!resetn)
    t2_overflow |=> !t2_overflow) else $error("timer 2 overflow too close");
  t2_reload_a: assert property (@(posedge core_clk) disable iff (!resetn)
    t2_ovf |=> t2_cnt_q == $past({timer2_reload_high, timer2_reload_low})) else $error("timer 2 reload wrong");
  t1_reload_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (t1_auto && pre12_q == PRE12_LAST && t1_cnt_q == 8'hFF) |=> t1_cnt_q == $past(timer1_reload_byte))
    else $error("timer 1 reload wrong");
  t1_prescale_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (t1_auto && pre12_q == PRE12_LAST) |=> pre12_q == 4'h0) else $error("timer 1 prescale wrong");
  t2_route_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (var_mode && timer2_tx_source_select && !t2_ovf) |=> !tx_tick_q) else $error("tx tick without timer 2");
  rx_route_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (var_mode && !timer2_rx_source_select && !t1_ovf) |=> !rx_tick_q) else $error("rx tick without timer 1");
  div_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_bit_tick |-> tx_div_q == 5'h00) else $error("tx divider not restarted");

  // Receive tick shape, receive timer 2 routing and transmit timer 1 routing
  rx_single_a: assert property (@(posedge core_clk) disable iff (!resetn)
    rx_bit_tick |=> !rx_bit_tick) else $error("rx tick longer than one cycle");
  rx_t2_route_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (var_mode && timer2_rx_source_select && !t2_ovf) |=> !rx_tick_q) else $error("rx tick without timer 2");
  tx_t1_route_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (var_mode && !timer2_tx_source_select && !t1_ovf) |=> !tx_tick_q) else $error("tx tick without timer 1");

  // Overflow flags follow the internal pulses
  t1_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    t1_ovf |=> t1_overflow) else $error("timer 1 overflow flag missing");
  t2_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    t2_ovf |=> t2_overflow) else $error("timer 2 overflow flag missing");
  t2_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !t2_baud |=> !t2_overflow) else $error("timer 2 overflow while unselected");

  // Counting pace of both timers
  t2_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (t2_baud && pre2_q == 1'b0) |=> t2_cnt_q == $past(t2_cnt_q)) else $error("timer 2 counted too fast");
  t1_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (t1_auto && pre12_q != PRE12_LAST) |=> t1_cnt_q == $past(t1_cnt_q)) else $error("timer 1 counted early");
  t1_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (t1_auto && pre12_q == PRE12_LAST && t1_cnt_q != 8'hFF) |=> t1_cnt_q == $past(t1_cnt_q) + 8'h01)
    else $error("timer 1 step wrong");

  // The whole 16-bit reload must reach the counter, high byte included
  // Dividers restart on each tick, so a rate change settles within one bit
endmodule : uart_baud_rate_generator

// ==== serial_partner.sv ====
/* Far-side serial logic model: counts bit ticks per direction.
 Assumes one-cycle ticks on core_clk. */
`timescale 1ns/1ns
module serial_partner (
  // Clock, reset and ticks
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic tx_bit_tick,
  input  wire logic rx_bit_tick,
  // Bits moved
  output int        tx_bits,
  output int        rx_bits
);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_bits <= 0;
      rx_bits <= 0;
    end else begin
      tx_bits <= tx_bits + int'(tx_bit_tick);
      rx_bits <= rx_bits + int'(rx_bit_tick);
    end
  end
endmodule : serial_partner

// ==== uart_baud_rate_generator_tb.sv ====
/* Bench for the bit-rate generator: tick gaps queued and compared.
 Assumes baud_gen_pkg and serial_partner. */
`timescale 1ns/1ns
module uart_baud_rate_generator_tb import baud_gen_pkg::*;;
  logic        core_clk, resetn, serial_mode_upper_bit, serial_mode_lower_bit, rate_double_bit;
  logic        timer1_run, t1_ovf_ext, ext_on, timer2_tx_source_select, timer2_rx_source_select;
  logic [3:0]  timer_mode_reg;
  logic [7:0]  timer1_reload_byte, timer2_reload_high, timer2_reload_low;
  wire logic   tx_bit_tick, rx_bit_tick, t1_overflow, t2_overflow;
  int          tx_bits, rx_bits, err_count, n_checks, cyc, tx_last, rx_last, t0, r0, ovf1_n, ovf2_n;
  int          tx_q[$], rx_q[$];
  logic [31:0] lfsr = 32'h46E71B77;
  uart_baud_rate_generator u_uart_baud_rate_generator (.core_clk, .resetn, .serial_mode_upper_bit,
    .serial_mode_lower_bit, .rate_double_bit, .timer_mode_reg, .timer1_reload_byte, .timer1_run,
    .t1_ovf_ext, .timer2_tx_source_select, .timer2_rx_source_select, .timer2_reload_high,
    .timer2_reload_low, .tx_bit_tick, .rx_bit_tick, .t1_overflow, .t2_overflow);
  serial_partner u_serial_partner (.core_clk, .resetn, .tx_bit_tick, .rx_bit_tick, .tx_bits, .rx_bits);
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic check(string what, int seen, int exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Let a change settle, then note two steady gaps
  task automatic meas(int gap);
    repeat (2) @(posedge core_clk iff tx_bit_tick === 1'b1);
    @(negedge core_clk);
    tx_q.push_back(gap);
    tx_q.push_back(gap);
    repeat (3) @(posedge core_clk iff tx_bit_tick === 1'b1);
    $display("test done gap %0d", gap);
  endtask : meas
  task automatic ovf_per_tick(bit t2, int exp);
    int s;
    @(posedge core_clk iff tx_bit_tick === 1'b1);
    s = t2 ? ovf2_n : ovf1_n;
    @(posedge core_clk iff tx_bit_tick === 1'b1);
    check(t2 ? "t2_ovf_per_bit" : "t1_ovf_per_bit", (t2 ? ovf2_n : ovf1_n) - s, exp);
  endtask : ovf_per_tick
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    t1_ovf_ext <= ext_on && (cyc % 10 == 0);
    ovf1_n <= ovf1_n + int'(t1_overflow === 1'b1);
    ovf2_n <= ovf2_n + int'(t2_overflow === 1'b1);
    if (cyc > 80000) begin
      err_count++;
      stop_test();
    end
    if (tx_bit_tick === 1'b1) begin
      if (tx_q.size() > 0) check("tx_gap", cyc - tx_last, tx_q.pop_front());
      tx_last = cyc;
    end
    if (rx_bit_tick === 1'b1) begin
      if (rx_q.size() > 0) check("rx_gap", cyc - rx_last, rx_q.pop_front());
      rx_last = cyc;
    end
  end
  initial begin
    {resetn, serial_mode_upper_bit, rate_double_bit, ext_on, timer2_tx_source_select} = '0;
    {serial_mode_lower_bit, timer1_run, timer2_rx_source_select} = '1;
    timer_mode_reg = T1_MODE_AUTO8;
    timer1_reload_byte = 8'hFF;
    {timer2_reload_high, timer2_reload_low} = 16'hFFF0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      timer1_reload_byte <= {5'h1F, lfsr[2:0]};
      rate_double_bit <= i[0];
      meas(T1_PRESCALE * (8 - int'(lfsr[2:0])) * (i[0] ? 16 : 32));
    end
    timer_mode_reg <= 4'h0;
    ext_on <= 1'b1;
    meas(10 * 32);
    ovf_per_tick(1'b0, 32);
    for (int m = 0; m < 3; m += 2) begin
      {serial_mode_upper_bit, serial_mode_lower_bit} <= m[1:0];
      repeat (3) @(posedge core_clk);
      t0 = tx_bits;
      r0 = rx_bits;
      repeat (1000) @(posedge core_clk);
      check("idle_ticks", tx_bits - t0, 0);
      check("idle_rx_ticks", rx_bits - r0, 0);
      $display("test done mode %0d", m);
    end
    {serial_mode_upper_bit, serial_mode_lower_bit} <= 2'h3;
    timer2_tx_source_select <= 1'b1;
    meas(T2_PRESCALE * 16 * 16);
    ovf_per_tick(1'b1, 16);
    timer2_tx_source_select <= 1'b0;
    @(negedge core_clk);
    rx_q.push_back(T2_PRESCALE * 16 * 16);
    rx_q.push_back(T2_PRESCALE * 16 * 16);
    meas(10 * 32);
    check("rx_left", rx_q.size(), 0);
    stop_test();
  end
endmodule : uart_baud_rate_generator_tb
